/* rtl/dsfd_pkg.sv */
// Package for the special-function decoder: codes, field positions, reset values, types
package dsfd_pkg;

  // ==========================================================================
  // Frame layout
  localparam logic [4:0] FRAME_BITS = 5'h18;
  localparam logic [4:0] CNT_MAX = 5'h1F;
  localparam logic [1:0] TARGET_SPECIAL = 2'h0;

  // ==========================================================================
  // Function codes
  localparam logic [5:0] FN_NOP = 6'h00;
  localparam logic [5:0] FN_CTRL = 6'h01;
  localparam logic [5:0] FN_OFS_FIRST = 6'h02;
  localparam logic [5:0] FN_OFS_SECOND = 6'h03;
  localparam logic [5:0] FN_RSV_LOW = 6'h04;
  localparam logic [5:0] FN_READBACK = 6'h05;
  localparam logic [5:0] FN_BANK_FIRST = 6'h06;
  localparam logic [5:0] FN_BANK_SECOND = 6'h07;
  localparam logic [5:0] FN_RSV_HIGH = 6'h08;

  // ==========================================================================
  // Control register bit positions and field widths
  localparam int CTRL_POWER_DOWN = 0;
  localparam int CTRL_THERMAL_EN = 1;
  localparam int CTRL_BANK_B = 2;
  localparam int CTRL_PKT_ERR = 3;
  localparam int CTRL_OVER_TEMP = 4;
  localparam int CTRL_WR_W = 3;
  localparam int OFS_W = 14;
  localparam int BANK_W = 8;

  // ==========================================================================
  // Readback address field and codes
  localparam int RB_ADDR_LSB = 7;
  localparam int RB_ADDR_W = 6;
  localparam logic [5:0] RB_CTRL = 6'h01;
  localparam logic [5:0] RB_OFS_FIRST = 6'h02;
  localparam logic [5:0] RB_OFS_SECOND = 6'h03;
  localparam logic [5:0] RB_BANK_FIRST = 6'h04;
  localparam logic [5:0] RB_BANK_SECOND = 6'h05;

  // ==========================================================================
  // Reset values
  localparam logic [2:0] CTRL_RST = 3'h0;
  localparam logic [13:0] OFS_RST = 14'h0000;
  localparam logic [7:0] BANK_RST = 8'h00;
  localparam logic [5:0] RB_ADDR_RST = 6'h00;
  // Pin order {over_temp, sdi, sync_n, sclk}; clock and sync idle high
  localparam logic [3:0] PIN_IDLE = 4'h3;

  // ==========================================================================
  // Types
  typedef struct packed {
    logic [1:0] target;
    logic [5:0] code;
    logic [15:0] payload;
  } dsfd_frame_t;

  typedef enum logic [0:0] {
    ST_IDLE = 1'b0,
    ST_RX = 1'b1
  } dsfd_state_t;

endpackage : dsfd_pkg

/* rtl/dsfd_sync.sv */
// Two-stage synchroniser with a delayed copy for edge finding
`timescale 1ns/1ns
`default_nettype none

module dsfd_sync (
  input wire logic i_sys_clk,
  input wire logic i_rst,
  input wire logic [3:0] i_async,
  output logic [3:0] o_level,
  output logic [3:0] o_level_prev
);

  logic [3:0] meta_q;
  logic [3:0] meta_d;
  logic [3:0] lvl_q;
  logic [3:0] lvl_d;
  logic [3:0] prev_q;
  logic [3:0] prev_d;

  always_comb begin
    meta_d = i_async;
    lvl_d = meta_q;
    prev_d = lvl_q;
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      meta_q <= dsfd_pkg::PIN_IDLE;
      lvl_q <= dsfd_pkg::PIN_IDLE;
      prev_q <= dsfd_pkg::PIN_IDLE;
    end else begin
      meta_q <= meta_d;
      lvl_q <= lvl_d;
      prev_q <= prev_d;
    end
  end

  assign o_level = lvl_q;
  assign o_level_prev = prev_q;

endmodule : dsfd_sync

`default_nettype wire

/* rtl/dsfd_decoder.sv */
// Serial special-function word decoder with control, offset, bank and readback registers
//
// How it works
// - Target bits 00 mean special function frame
// - Code 000001 writes three control bits
// - Bit 4 shows die over-temperature flag
// - Bit 3 shows pending packet check failure
// - Bit 2 selects input bank B
// - Bit 1 enables thermal shutdown
// - Bit 0 forces software power-down
// - Code 000010 loads first offset, 14 bits
// - Code 000011 loads second offset, 14 bits
// - Code 000101 records readback register address
// - Next frame shifts selected register out serially
// - Code 000110 loads first bank choice byte
// - Code 000111 loads second bank choice byte
// - Reading control clears error flag and output
`timescale 1ns/1ns
`default_nettype none

module dsfd_decoder (
  input wire logic i_sys_clk,
  input wire logic i_rst,
  input wire logic i_sclk,
  input wire logic i_sync_n,
  input wire logic i_sdi,
  input wire logic i_over_temp,
  input wire logic i_pkt_chk_fail,
  output logic o_sdo,
  output logic o_sdo_oe,
  output logic o_pkt_err_n,
  output logic o_input_bank_b,
  output logic o_thermal_en,
  output logic o_thermal_shutdown,
  output logic o_power_down,
  output logic [13:0] o_offset_dac_first,
  output logic [13:0] o_offset_dac_second,
  output logic [7:0] o_bank_choice_first,
  output logic [7:0] o_bank_choice_second
);

  // ==========================================================================
  // Pin synchronisers
  logic [3:0] lvl;
  logic [3:0] lvl_prev;

  dsfd_sync u_sync (
    .i_sys_clk(i_sys_clk),
    .i_rst(i_rst),
    .i_async({i_over_temp, i_sdi, i_sync_n, i_sclk}),
    .o_level(lvl),
    .o_level_prev(lvl_prev)
  );

  logic sclk_rise;
  logic sclk_fall;
  logic sync_rise;
  logic sync_fall;
  logic sdi_s;
  logic over_temp_s;

  assign sclk_rise = lvl[0] & ~lvl_prev[0];
  assign sclk_fall = ~lvl[0] & lvl_prev[0];
  assign sync_rise = lvl[1] & ~lvl_prev[1];
  assign sync_fall = ~lvl[1] & lvl_prev[1];
  assign sdi_s = lvl[2];
  assign over_temp_s = lvl[3];

  // ==========================================================================
  // State
  dsfd_pkg::dsfd_state_t st_q;
  dsfd_pkg::dsfd_state_t st_d;
  logic [4:0] cnt_q;
  logic [4:0] cnt_d;
  logic [23:0] sh_q;
  logic [23:0] sh_d;
  logic [23:0] tx_q;
  logic [23:0] tx_d;
  logic [2:0] ctrl_q;
  logic [2:0] ctrl_d;
  logic perr_q;
  logic perr_d;
  logic [13:0] ofs_a_q;
  logic [13:0] ofs_a_d;
  logic [13:0] ofs_b_q;
  logic [13:0] ofs_b_d;
  logic [7:0] bank0_q;
  logic [7:0] bank0_d;
  logic [7:0] bank1_q;
  logic [7:0] bank1_d;
  logic [5:0] rb_addr_q;
  logic [5:0] rb_addr_d;
  logic rb_armed_q;
  logic rb_armed_d;
  logic rb_busy_q;
  logic rb_busy_d;

  dsfd_pkg::dsfd_frame_t frame;
  logic frame_done;
  logic special;

  assign frame = dsfd_pkg::dsfd_frame_t'(sh_q);
  assign frame_done = (st_q == dsfd_pkg::ST_RX) && sync_rise &&
                      (cnt_q == dsfd_pkg::FRAME_BITS);
  assign special = frame_done && (frame.target == dsfd_pkg::TARGET_SPECIAL);

  // ==========================================================================
  // Readback source selection
  function automatic logic [23:0] rb_data(input logic [5:0] addr, input logic [2:0] ctrl,
                                          input logic err, input logic hot,
                                          input logic [13:0] o0, input logic [13:0] o1,
                                          input logic [7:0] b0, input logic [7:0] b1);
    logic [23:0] val;
    val = 24'h00_0000;
    case (addr)
      dsfd_pkg::RB_CTRL: val = {19'h0_0000, hot, err, ctrl};
      dsfd_pkg::RB_OFS_FIRST: val = {10'h000, o0};
      dsfd_pkg::RB_OFS_SECOND: val = {10'h000, o1};
      dsfd_pkg::RB_BANK_FIRST: val = {16'h0000, b0};
      dsfd_pkg::RB_BANK_SECOND: val = {16'h0000, b1};
      default: val = 24'h00_0000;
    endcase
    return val;
  endfunction : rb_data

  // ==========================================================================
  // Next-state logic
  always_comb begin
    st_d = st_q;
    cnt_d = cnt_q;
    sh_d = sh_q;
    tx_d = tx_q;
    ctrl_d = ctrl_q;
    perr_d = perr_q;
    ofs_a_d = ofs_a_q;
    ofs_b_d = ofs_b_q;
    bank0_d = bank0_q;
    bank1_d = bank1_q;
    rb_addr_d = rb_addr_q;
    rb_armed_d = rb_armed_q;
    rb_busy_d = rb_busy_q;
    case (st_q)
      dsfd_pkg::ST_IDLE: begin
        if (sync_fall) begin
          st_d = dsfd_pkg::ST_RX;
          cnt_d = 5'h00;
          if (rb_armed_q) begin
            rb_busy_d = 1'b1;
            tx_d = rb_data(rb_addr_q, ctrl_q, perr_q, over_temp_s, ofs_a_q, ofs_b_q,
                           bank0_q, bank1_q);
          end
        end
      end
      dsfd_pkg::ST_RX: begin
        if (sclk_fall) begin
          sh_d = {sh_q[22:0], sdi_s};
          if (cnt_q != dsfd_pkg::CNT_MAX) begin
            cnt_d = cnt_q + 5'h01;
          end
        end
        if (sclk_rise && rb_busy_q && (cnt_q != 5'h00)) begin
          tx_d = {tx_q[22:0], 1'b0};
        end
        if (sync_rise) begin
          st_d = dsfd_pkg::ST_IDLE;
          if (rb_busy_q) begin
            rb_busy_d = 1'b0;
            rb_armed_d = 1'b0;
            if ((rb_addr_q == dsfd_pkg::RB_CTRL) && (cnt_q == dsfd_pkg::FRAME_BITS)) begin
              perr_d = 1'b0;
            end
          end
          if (special) begin
            case (frame.code)
              dsfd_pkg::FN_CTRL: ctrl_d = frame.payload[dsfd_pkg::CTRL_WR_W-1:0];
              dsfd_pkg::FN_OFS_FIRST: ofs_a_d = frame.payload[dsfd_pkg::OFS_W-1:0];
              dsfd_pkg::FN_OFS_SECOND: ofs_b_d = frame.payload[dsfd_pkg::OFS_W-1:0];
              dsfd_pkg::FN_READBACK: begin
                rb_addr_d = frame.payload[dsfd_pkg::RB_ADDR_LSB +: dsfd_pkg::RB_ADDR_W];
                rb_armed_d = 1'b1;
              end
              dsfd_pkg::FN_BANK_FIRST: bank0_d = frame.payload[dsfd_pkg::BANK_W-1:0];
              dsfd_pkg::FN_BANK_SECOND: bank1_d = frame.payload[dsfd_pkg::BANK_W-1:0];
              default: ;
            endcase
          end
        end
      end
      default: st_d = dsfd_pkg::ST_IDLE;
    endcase
    // Set wins over the readback clear
    if (i_pkt_chk_fail) begin
      perr_d = 1'b1;
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      st_q <= dsfd_pkg::ST_IDLE;
      cnt_q <= 5'h00;
      sh_q <= 24'h00_0000;
      tx_q <= 24'h00_0000;
      ctrl_q <= dsfd_pkg::CTRL_RST;
      perr_q <= 1'b0;
      ofs_a_q <= dsfd_pkg::OFS_RST;
      ofs_b_q <= dsfd_pkg::OFS_RST;
      bank0_q <= dsfd_pkg::BANK_RST;
      bank1_q <= dsfd_pkg::BANK_RST;
      rb_addr_q <= dsfd_pkg::RB_ADDR_RST;
      rb_armed_q <= 1'b0;
      rb_busy_q <= 1'b0;
    end else begin
      st_q <= st_d;
      cnt_q <= cnt_d;
      sh_q <= sh_d;
      tx_q <= tx_d;
      ctrl_q <= ctrl_d;
      perr_q <= perr_d;
      ofs_a_q <= ofs_a_d;
      ofs_b_q <= ofs_b_d;
      bank0_q <= bank0_d;
      bank1_q <= bank1_d;
      rb_addr_q <= rb_addr_d;
      rb_armed_q <= rb_armed_d;
      rb_busy_q <= rb_busy_d;
    end
  end

  // ==========================================================================
  // Outputs
  assign o_sdo = tx_q[23];
  assign o_sdo_oe = rb_armed_q;
  assign o_pkt_err_n = ~perr_q;
  assign o_input_bank_b = ctrl_q[dsfd_pkg::CTRL_BANK_B];
  assign o_thermal_en = ctrl_q[dsfd_pkg::CTRL_THERMAL_EN];
  assign o_thermal_shutdown = ctrl_q[dsfd_pkg::CTRL_THERMAL_EN] & over_temp_s;
  assign o_power_down = ctrl_q[dsfd_pkg::CTRL_POWER_DOWN];
  assign o_offset_dac_first = ofs_a_q;
  assign o_offset_dac_second = ofs_b_q;
  assign o_bank_choice_first = bank0_q;
  assign o_bank_choice_second = bank1_q;

  // ==========================================================================
  // Assertions
  logic ctrl_read_end;
  assign ctrl_read_end = frame_done && rb_busy_q && (rb_addr_q == dsfd_pkg::RB_CTRL);

  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (i_rst);

  AST_CTRL_WRITE: assert property (
    special && frame.code == dsfd_pkg::FN_CTRL |=>
      {o_input_bank_b, o_thermal_en, o_power_down} == $past(frame.payload[2:0]))
    else $error("control write not applied");

  AST_OFS_FIRST: assert property (
    special && frame.code == dsfd_pkg::FN_OFS_FIRST |=>
      o_offset_dac_first == $past(frame.payload[13:0]))
    else $error("first offset not loaded");

  AST_OFS_SECOND: assert property (
    special && frame.code == dsfd_pkg::FN_OFS_SECOND |=>
      o_offset_dac_second == $past(frame.payload[13:0]) && $stable(o_offset_dac_first))
    else $error("second offset not loaded");

  AST_BANK_FIRST: assert property (
    special && frame.code == dsfd_pkg::FN_BANK_FIRST |=>
      o_bank_choice_first == $past(frame.payload[7:0]))
    else $error("first bank choice not loaded");

  AST_BANK_SECOND: assert property (
    special && frame.code == dsfd_pkg::FN_BANK_SECOND |=>
      o_bank_choice_second == $past(frame.payload[7:0]) && $stable(o_bank_choice_first))
    else $error("second bank choice not loaded");

  AST_READBACK_ARM: assert property (
    special && frame.code == dsfd_pkg::FN_READBACK |=>
      o_sdo_oe && rb_addr_q == $past(frame.payload[12:7]))
    else $error("readback not armed");

  AST_ERR_SET: assert property (
    i_pkt_chk_fail |=> !o_pkt_err_n ##1 (!o_pkt_err_n || $past(ctrl_read_end)))
    else $error("packet error flag lost");

  AST_ERR_CLEAR: assert property (
    ctrl_read_end && !i_pkt_chk_fail |=>
      o_pkt_err_n && (o_sdo_oe == $past(special && frame.code == dsfd_pkg::FN_READBACK)))
    else $error("error flag not cleared by control read");

  AST_INCOMPLETE: assert property (
    st_q == dsfd_pkg::ST_RX && sync_rise && cnt_q != dsfd_pkg::FRAME_BITS |=>
      $stable(ctrl_q) && $stable(ofs_a_q) && $stable(ofs_b_q) && $stable(bank0_q)
      && $stable(bank1_q))
    else $error("incomplete frame changed state");

  AST_RESERVED: assert property (
    special && (frame.code == dsfd_pkg::FN_RSV_LOW || frame.code == dsfd_pkg::FN_RSV_HIGH
      || frame.code == dsfd_pkg::FN_NOP) |=>
      $stable(ctrl_q) && $stable(ofs_a_q) && $stable(ofs_b_q) && $stable(bank0_q)
      && $stable(bank1_q) && $stable(rb_addr_q))
    else $error("reserved code changed state");

endmodule : dsfd_decoder

`default_nettype wire

/* verif/dsfd_host_model.sv */
// Host controller model driving the serial frame pins of the decoder
`timescale 1ns/1ns
`default_nettype none

module dsfd_host_model (
  input wire logic i_sys_clk,
  input wire logic i_sdo,
  input wire logic i_sdo_oe,
  output logic o_sclk,
  output logic o_sync_n,
  output logic o_sdi
);
  initial begin
    o_sclk = 1'b1;
    o_sync_n = 1'b1;
    o_sdi = 1'b0;
  end

  task automatic step(input int k);
    repeat (k) @(posedge i_sys_clk);
    #1;
  endtask : step

  // ==========================================================================
  // One frame of n bits, MSB first; returns what the decoder shifted out
  task automatic frame(input logic [31:0] w, input int n, output logic [23:0] rx);
    rx = 24'h00_0000;
    o_sync_n = 1'b0;
    step(4);
    for (int i = 0; i < n; i++) begin
      o_sdi = w[n - 1 - i];
      step(4);
      o_sclk = 1'b0;
      step(4);
      // Bit stands from the previous rise until the next one
      // Undriven line reads as the inverse of the last value
      rx = {rx[22:0], i_sdo_oe ? i_sdo : ~i_sdo};
      o_sclk = 1'b1;
    end
    step(4);
    o_sync_n = 1'b1;
    // Released data line shows no stale value
    o_sdi = ~o_sdi;
    step(8);
  endtask : frame
endmodule : dsfd_host_model

`default_nettype wire

/* verif/dsfd_decoder_tb.sv */
// Self-checking testbench for the special-function decoder
`timescale 1ns/1ns
`default_nettype none

`define CHK(nm, e, g) begin total_checks++; if ((g) !== (e)) begin fail_count++; $display("mismatch %s expected %h seen %h", nm, e, g); end end

module dsfd_decoder_tb;
  logic i_sys_clk = 1'b0;
  logic i_rst = 1'b1;
  logic over_temp = 1'b0;
  logic err_inj = 1'b0;
  wire logic sclk, sync_n, sdi, sdo, sdo_oe, err_n, bank_b, th_en, th_sd, pwr_dn;
  wire logic [13:0] ofs_a, ofs_b;
  wire logic [7:0] bk0, bk1;
  int fail_count = 0;
  int total_checks = 0;
  logic [23:0] rx;
  logic [23:0] exp_rb [4] = '{24'h00_3FFF, 24'h00_1A5A, 24'h00_005C, 24'h00_00C3};

  always #5 i_sys_clk = ~i_sys_clk;

  dsfd_decoder dut (.i_sys_clk(i_sys_clk), .i_rst(i_rst), .i_sclk(sclk), .i_sync_n(sync_n),
    .i_sdi(sdi), .i_over_temp(over_temp), .i_pkt_chk_fail(err_inj), .o_sdo(sdo),
    .o_sdo_oe(sdo_oe), .o_pkt_err_n(err_n), .o_input_bank_b(bank_b), .o_thermal_en(th_en),
    .o_thermal_shutdown(th_sd), .o_power_down(pwr_dn), .o_offset_dac_first(ofs_a),
    .o_offset_dac_second(ofs_b), .o_bank_choice_first(bk0), .o_bank_choice_second(bk1));

  dsfd_host_model host (.i_sys_clk(i_sys_clk), .i_sdo(sdo), .i_sdo_oe(sdo_oe), .o_sclk(sclk),
    .o_sync_n(sync_n), .o_sdi(sdi));

  // ==========================================================================
  // Access tasks
  task automatic sf(input logic [5:0] c, input logic [15:0] p);
    host.frame({8'h00, 2'h0, c, p}, 24, rx);
  endtask : sf

  task automatic rd(input logic [5:0] a, output logic [23:0] v);
    sf(dsfd_pkg::FN_READBACK, {3'h0, a, 7'h00});
    `CHK("sdo_oe armed", 1'b1, sdo_oe)
    host.frame(32'h0000_0000, 24, v);
    `CHK("sdo_oe released", 1'b0, sdo_oe)
  endtask : rd

  task automatic test_done();
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : test_done

  initial begin
    #500000;
    fail_count++;
    test_done();
  end

  // ==========================================================================
  // Test sequence
  initial begin
    repeat (8) @(posedge i_sys_clk);
    #1;
    i_rst = 1'b0;
    host.step(4);
    `CHK("err_n reset", 1'b1, err_n)
    `CHK("sdo_oe reset", 1'b0, sdo_oe)
    `CHK("offset first reset", 14'h0000, ofs_a)
    // Control write, upper payload set, read-only places zero
    sf(dsfd_pkg::FN_CTRL, 16'hFFE7);
    `CHK("power_down", 1'b1, pwr_dn)
    `CHK("thermal_en", 1'b1, th_en)
    `CHK("bank_b", 1'b1, bank_b)
    rd(dsfd_pkg::RB_CTRL, rx);
    `CHK("ctrl readback", 24'h00_0007, rx)
    sf(dsfd_pkg::FN_CTRL, 16'h0002);
    `CHK("power_up", 1'b0, pwr_dn)
    `CHK("bank_a", 1'b0, bank_b)
    over_temp = 1'b1;
    host.step(6);
    `CHK("thermal_shutdown", 1'b1, th_sd)
    rd(dsfd_pkg::RB_CTRL, rx);
    `CHK("ctrl hot", 24'h00_0012, rx)
    over_temp = 1'b0;
    // Register loads, ignored upper payload bits
    sf(dsfd_pkg::FN_OFS_FIRST, 16'hFFFF);
    `CHK("offset first", 14'h3FFF, ofs_a)
    `CHK("thermal_shutdown off", 1'b0, th_sd)
    sf(dsfd_pkg::FN_OFS_SECOND, 16'h5A5A);
    `CHK("offset second", 14'h1A5A, ofs_b)
    sf(dsfd_pkg::FN_BANK_FIRST, 16'hAB5C);
    `CHK("bank first", 8'h5C, bk0)
    sf(dsfd_pkg::FN_BANK_SECOND, 16'h12C3);
    `CHK("bank second", 8'hC3, bk1)
    for (int i = 0; i < 4; i++) begin
      rd(dsfd_pkg::RB_OFS_FIRST + 6'(i), rx);
      `CHK("readback", exp_rb[i], rx)
    end
    // Frames that must change nothing
    sf(dsfd_pkg::FN_NOP, 16'h0000);
    sf(dsfd_pkg::FN_RSV_LOW, 16'h1234);
    sf(dsfd_pkg::FN_RSV_HIGH, 16'h1234);
    host.frame(32'h0042_1234, 24, rx);
    host.frame(32'h0002_1234, 23, rx);
    host.frame(32'h0212_3400, 32, rx);
    `CHK("offset first kept", 14'h3FFF, ofs_a)
    `CHK("offset second kept", 14'h1A5A, ofs_b)
    `CHK("bank first kept", 8'h5C, bk0)
    `CHK("ctrl kept", 1'b1, th_en)
    // Packet error flag, cleared by control readback
    @(posedge i_sys_clk);
    #1;
    err_inj = 1'b1;
    host.step(1);
    err_inj = 1'b0;
    host.step(2);
    `CHK("err_n low", 1'b0, err_n)
    rd(dsfd_pkg::RB_CTRL, rx);
    `CHK("ctrl error", 24'h00_000A, rx)
    `CHK("err_n cleared", 1'b1, err_n)
    rd(dsfd_pkg::RB_CTRL, rx);
    `CHK("ctrl error gone", 24'h00_0002, rx)
    test_done();
  end
endmodule : dsfd_decoder_tb

`default_nettype wire
